// ===== hdl/port_drive_pkg.sv
package port_drive_pkg;
    // ==========================================================
    // Geometry
    localparam int          DATA_W       = 32;
    localparam int          ADDR_W       = 8;
    localparam int          GROUPS       = 2;
    localparam int          GROUP_BIT    = 7;
    localparam logic [7:0]  GROUP_STRIDE = 8'h80;
    // ==========================================================
    // Register offsets within one group
    localparam logic [6:0]  OFF_LEVEL    = 7'h10;
    localparam logic [6:0]  OFF_CLEAR    = 7'h14;
    localparam logic [6:0]  OFF_RAISE    = 7'h18;
    localparam logic [6:0]  OFF_FLIP     = 7'h1C;
    // ==========================================================
    // Reset values and bus answers
    localparam logic [31:0] LEVEL_RESET  = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    // ==========================================================
    // Kinds of register access
    typedef enum logic [2:0] {
        ACC_NONE,
        ACC_LEVEL,
        ACC_CLEAR,
        ACC_RAISE,
        ACC_FLIP
    } acc_kind_t;
endpackage

// ===== hdl/port_output_drive_regs.sv
`timescale 1ns/1ps
// Behaviour
// - Output pins drive the level held in their drive-level bit.
// - Input pins with pull enabled: bit 0 pulls down, bit 1 pulls up.
// - Writing 1 to a clear bit forces that drive-level bit to 0.
// - Clear bits written as 0 leave drive level unchanged.
// - Reads of set, clear or toggle return the current drive level.
// - Each 32-pin group has its own registers, groups 0x80 apart.
// - One set write raises all selected bits at once.
// - Writing 1 to a set bit makes that drive-level bit 1; 0 ignored.
module port_output_drive_regs (
    input  wire logic                                            aclk,
    input  wire logic                                            aresetn,
    input  wire logic [port_drive_pkg::ADDR_W-1:0]               s_axi_awaddr,
    input  wire logic                                            s_axi_awvalid,
    output logic                                                 s_axi_awready,
    input  wire logic [31:0]                                     s_axi_wdata,
    input  wire logic [3:0]                                      s_axi_wstrb,
    input  wire logic                                            s_axi_wvalid,
    output logic                                                 s_axi_wready,
    output logic [1:0]                                           s_axi_bresp,
    output logic                                                 s_axi_bvalid,
    input  wire logic                                            s_axi_bready,
    input  wire logic [port_drive_pkg::ADDR_W-1:0]               s_axi_araddr,
    input  wire logic                                            s_axi_arvalid,
    output logic                                                 s_axi_arready,
    output logic [31:0]                                          s_axi_rdata,
    output logic [1:0]                                           s_axi_rresp,
    output logic                                                 s_axi_rvalid,
    input  wire logic                                            s_axi_rready,
    input  wire logic                                            write_guard,
    input  wire logic [port_drive_pkg::GROUPS*32-1:0]            pin_dir,
    input  wire logic [port_drive_pkg::GROUPS*32-1:0]            pull_enable_bit,
    output logic [port_drive_pkg::GROUPS*32-1:0]                 pin_level,
    output logic [port_drive_pkg::GROUPS*32-1:0]                 pin_oe,
    output logic [port_drive_pkg::GROUPS*32-1:0]                 pull_up_en,
    output logic [port_drive_pkg::GROUPS*32-1:0]                 pull_down_en
);
    // ==========================================================
    // Decode helpers
    function automatic port_drive_pkg::acc_kind_t decode(input logic [6:0] off);
        case (off)
            port_drive_pkg::OFF_LEVEL: decode = port_drive_pkg::ACC_LEVEL;
            port_drive_pkg::OFF_CLEAR: decode = port_drive_pkg::ACC_CLEAR;
            port_drive_pkg::OFF_RAISE: decode = port_drive_pkg::ACC_RAISE;
            port_drive_pkg::OFF_FLIP:  decode = port_drive_pkg::ACC_FLIP;
            default:                   decode = port_drive_pkg::ACC_NONE;
        endcase
    endfunction

    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    // ==========================================================
    // Write channel state
    logic [port_drive_pkg::ADDR_W-1:0] aw_addr_reg;
    logic                              aw_hold_reg;
    logic [31:0]                       w_data_reg;
    logic [3:0]                        w_strb_reg;
    logic                              w_hold_reg;
    logic                              wr_fire;
    logic                              wr_grp;
    port_drive_pkg::acc_kind_t         wr_kind;
    logic [31:0]                       wr_mask;
    logic [31:0]                       level_reg [port_drive_pkg::GROUPS];

    // Commit once address and data are both held and no answer pending
    assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    assign wr_grp  = aw_addr_reg[port_drive_pkg::GROUP_BIT];
    assign wr_kind = decode(aw_addr_reg[6:0]);
    assign wr_mask = lane_mask(w_strb_reg);

    // Address capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg   <= 1'b0;
            aw_addr_reg   <= '0;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg   <= 1'b1;
            aw_addr_reg   <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else begin
            if (wr_fire) begin
                aw_hold_reg <= 1'b0;
            end
            s_axi_awready <= !aw_hold_reg && !s_axi_bvalid;
        end
    end

    // Data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_reg   <= 1'b0;
            w_data_reg   <= '0;
            w_strb_reg   <= '0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg   <= 1'b1;
            w_data_reg   <= s_axi_wdata;
            w_strb_reg   <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else begin
            if (wr_fire) begin
                w_hold_reg <= 1'b0;
            end
            s_axi_wready <= !w_hold_reg && !s_axi_bvalid;
        end
    end

    // guarded write
    // Write answer: error for unmapped offsets and guarded writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= port_drive_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_kind == port_drive_pkg::ACC_NONE || write_guard) ?
                            port_drive_pkg::RESP_SLVERR : port_drive_pkg::RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Drive-level storage, one copy per group
    // per-group copy
    for (genvar g = 0; g < port_drive_pkg::GROUPS; g++) begin : g_group
        logic hit;
        assign hit = wr_fire && !write_guard && (wr_grp == 1'(g));
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                level_reg[g] <= port_drive_pkg::LEVEL_RESET;
            end else if (hit) begin
                case (wr_kind)
                    port_drive_pkg::ACC_LEVEL:
                        level_reg[g] <= (level_reg[g] & ~wr_mask) | (w_data_reg & wr_mask);
                    port_drive_pkg::ACC_CLEAR:
                        level_reg[g] <= level_reg[g] & ~(w_data_reg & wr_mask);
                    port_drive_pkg::ACC_RAISE:
                        level_reg[g] <= level_reg[g] | (w_data_reg & wr_mask);
                    port_drive_pkg::ACC_FLIP:
                        level_reg[g] <= level_reg[g] ^ (w_data_reg & wr_mask);
                    default:
                        level_reg[g] <= level_reg[g];
                endcase
            end
        end

        // Pin drivers follow the stored level
        assign pin_level[g*32 +: 32] = level_reg[g];

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                pin_oe[g*32 +: 32]       <= '0;
                pull_up_en[g*32 +: 32]   <= '0;
                pull_down_en[g*32 +: 32] <= '0;
            end else begin
                pin_oe[g*32 +: 32]       <= pin_dir[g*32 +: 32];
                pull_up_en[g*32 +: 32]   <= ~pin_dir[g*32 +: 32] &
                                            pull_enable_bit[g*32 +: 32] & level_reg[g];
                pull_down_en[g*32 +: 32] <= ~pin_dir[g*32 +: 32] &
                                            pull_enable_bit[g*32 +: 32] & ~level_reg[g];
            end
        end
    end

    // ==========================================================
    // Read channel
    port_drive_pkg::acc_kind_t rd_kind;
    logic                      rd_grp;
    assign rd_kind = decode(s_axi_araddr[6:0]);
    assign rd_grp  = s_axi_araddr[port_drive_pkg::GROUP_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= port_drive_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            if (rd_kind == port_drive_pkg::ACC_NONE) begin
                s_axi_rdata <= '0;
                s_axi_rresp <= port_drive_pkg::RESP_SLVERR;
            end else begin
                s_axi_rdata <= level_reg[rd_grp];
                s_axi_rresp <= port_drive_pkg::RESP_OKAY;
            end
        end else begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_rvalid;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic live0;
    assign live0 = wr_fire && !write_guard && !wr_grp;

    a_oe_follows_dir: assert property (
        pin_oe == $past(pin_dir) &&
        (pin_level[31:0] == $past(pin_level[31:0]) || $past(live0)))
        else $error("output enable or level not following state");
    a_level_write: assert property (
        (live0 && wr_kind == port_drive_pkg::ACC_LEVEL) |=>
        pin_level[31:0] == (($past(level_reg[0]) & ~$past(wr_mask)) |
                            $past(w_data_reg & wr_mask)))
        else $error("output level not written");
    a_pull_choice: assert property (
        (!$past(pin_dir[0]) && $past(pull_enable_bit[0])) |->
        (pull_up_en[0] == $past(level_reg[0][0])) && (pull_down_en[0] != pull_up_en[0]))
        else $error("pull direction wrong");
    a_clear_ones: assert property (
        (live0 && wr_kind == port_drive_pkg::ACC_CLEAR) |=>
        (level_reg[0] & $past(w_data_reg & wr_mask)) == 32'h0000_0000)
        else $error("clear did not lower bits");
    a_clear_zeros: assert property (
        (live0 && wr_kind == port_drive_pkg::ACC_CLEAR) |=>
        (level_reg[0] & ~$past(w_data_reg & wr_mask)) ==
        ($past(level_reg[0]) & ~$past(w_data_reg & wr_mask)))
        else $error("clear touched unselected bits");
    a_read_alias: assert property (
        (s_axi_arvalid && s_axi_arready && !rd_grp &&
         rd_kind inside {port_drive_pkg::ACC_CLEAR, port_drive_pkg::ACC_RAISE,
                         port_drive_pkg::ACC_FLIP}) |=>
        s_axi_rvalid && s_axi_rdata == $past(level_reg[0]))
        else $error("alias read differs from level");
    a_group_split: assert property (
        (wr_fire && wr_grp) |=> $stable(level_reg[0]))
        else $error("group 1 write changed group 0");
    a_raise_once: assert property (
        (live0 && wr_kind == port_drive_pkg::ACC_RAISE) |=>
        (level_reg[0] & $past(w_data_reg & wr_mask)) == $past(w_data_reg & wr_mask))
        else $error("set did not raise all bits");
    a_raise_zeros: assert property (
        (live0 && wr_kind == port_drive_pkg::ACC_RAISE) |=>
        (level_reg[0] & ~$past(w_data_reg & wr_mask)) ==
        ($past(level_reg[0]) & ~$past(w_data_reg & wr_mask)))
        else $error("set touched unselected bits");
    a_guard_blocks: assert property (
        (wr_fire && write_guard) |=> $stable(level_reg[0]) ##0 s_axi_bvalid
        ##0 s_axi_bresp == port_drive_pkg::RESP_SLVERR)
        else $error("guarded write took effect");

    c_clear_write: cover property (live0 && wr_kind == port_drive_pkg::ACC_CLEAR);
    c_raise_write: cover property (live0 && wr_kind == port_drive_pkg::ACC_RAISE);
    c_guarded:     cover property (wr_fire && write_guard);
    c_read_back:   cover property (s_axi_rvalid && s_axi_rready);
endmodule

// ===== dv/pin_pad_model.sv
`timescale 1ns/1ps
// ==========================================================
// Pad side of the pin group: driver, then pull, then outside source
module pin_pad_model #(
    parameter int N = 64
) (
    input  wire logic [N-1:0] pin_level,
    input  wire logic [N-1:0] pin_oe,
    input  wire logic [N-1:0] pull_up_en,
    input  wire logic [N-1:0] pull_down_en,
    input  wire logic [N-1:0] ext_drive,
    output logic      [N-1:0] pad
);
    // Resolve each pad from all parties
    always_comb begin
        for (int i = 0; i < N; i++) begin
            if (pin_oe[i]) pad[i] = pin_level[i];
            else if (pull_up_en[i]) pad[i] = 1'h1;
            else if (pull_down_en[i]) pad[i] = 1'h0;
            else pad[i] = ext_drive[i];
        end
    end
endmodule

// ===== dv/port_output_drive_regs_bench.sv
`timescale 1ns/1ps
// ==========================================================
// Bench for the drive-level registers
module port_output_drive_regs_bench;
    localparam int N = port_drive_pkg::GROUPS*32;
    logic         aclk = 1'h0, aresetn = 1'h0, guard = 1'h0;
    logic [7:0]   awaddr = 8'h00, araddr = 8'h00;
    logic [31:0]  wdata = 32'h0, rdata;
    logic [3:0]   wstrb = 4'h0;
    logic         awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic         arvalid = 1'h0, rready = 1'h0;
    logic         awready, wready, bvalid, arready, rvalid;
    logic [1:0]   bresp, rresp;
    logic [N-1:0] dir = '0, pen = '0, ext = '0, lvl, oe, pu, pd, pad, m;
    logic [31:0]  mdl [2];
    int           miscompares = 0, checked = 0, seed = 29820;

    port_output_drive_regs uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .write_guard(guard),
        .pin_dir(dir), .pull_enable_bit(pen), .pin_level(lvl), .pin_oe(oe),
        .pull_up_en(pu), .pull_down_en(pd));
    pin_pad_model #(.N(N)) pads (.pin_level(lvl), .pin_oe(oe), .pull_up_en(pu),
        .pull_down_en(pd), .ext_drive(ext), .pad(pad));

    // Clock and watchdog
    initial forever #5 aclk = ~aclk;
    initial begin
        #200000;
        miscompares++;
        tally_and_finish();
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (miscompares == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Write: offer AW and W together, hold each until taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [1:0] r);
        logic ta, tw, tb;
        int   n;
        tb = 1'h0;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!tb && n < 100) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid && bready;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
            if (tb) bready <= 1'h0;
            n++;
        end
        if (!tb) miscompares++;
    endtask

    // Read: hold AR until taken, rready until rvalid
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        int   n;
        tr = 1'h0;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        while (!tr && n < 100) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'h0;
            if (tr) rready <= 1'h0;
            n++;
        end
        if (!tr) miscompares++;
    endtask

    // Reference update for level, clear, raise, flip with byte lanes
    function automatic logic [31:0] apply(input logic [31:0] l, input int k,
                                          input logic [31:0] d, input logic [3:0] s);
        logic [31:0] b;
        b = d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        case (k)
            0: return (l & ~{{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}}) | b;
            1: return l & ~b;
            2: return l | b;
            3: return l ^ b;
            default: return l;
        endcase
    endfunction

    // Main sequence
    initial begin
        int          g, k;
        logic [31:0] d, rd;
        logic [3:0]  s;
        logic [1:0]  r, er;
        logic [6:0]  off;
        mdl[0] = 32'h0;
        mdl[1] = 32'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        // Reset value through every alias of both groups
        for (int i = 0; i < 8; i++) begin
            axr({i[2], 7'h10 + 7'(4 * (i % 4))}, rd, r);
            check(rd, 64'h0);
            check(r, port_drive_pkg::RESP_OKAY);
        end
        // Random traffic over all kinds, lanes, groups and guard
        for (int i = 0; i < 120; i++) begin
            g = $unsigned($random(seed)) % 2;
            k = $unsigned($random(seed)) % 6;
            d = $random(seed);
            s = 4'($random(seed));
            off = (k < 4) ? 7'h10 + 7'(4 * k) : ((k == 4) ? 7'h20 : 7'h04);
            dir <= {$random(seed), $random(seed)};
            pen <= {$random(seed), $random(seed)};
            ext <= {$random(seed), $random(seed)};
            guard <= ($random(seed) % 4) == 0;
            axw({g[0], off}, d, s, r);
            er = (guard || k > 3) ? port_drive_pkg::RESP_SLVERR : port_drive_pkg::RESP_OKAY;
            if (er == port_drive_pkg::RESP_OKAY) mdl[g] = apply(mdl[g], k, d, s);
            m = {mdl[1], mdl[0]};
            check(r, er);
            check(lvl, m);
            axr({g[0], off}, rd, r);
            check(rd, (k > 3) ? 32'h0 : mdl[g]);
            check(r, (k > 3) ? port_drive_pkg::RESP_SLVERR : port_drive_pkg::RESP_OKAY);
            check(oe, dir);
            check(pu, ~dir & pen & m);
            check(pd, ~dir & pen & ~m);
            check(pad, (dir & m) | (~dir & pen & m) | (~dir & ~pen & ext));
        end
        tally_and_finish();
    end
endmodule
